// [rtl/rrtxf_pkg.sv]
// package for the read response transmit framer
// Function
// - read responses leave on the transmit stream as 64-bit beats; the header loads in one cycle, payload one byte pair per cycle
// - header beat: ack id 63:59, reserved 58:57, critical flag 56, prio, tt
// - format type in bits 51:48; value 13 marks a response packet
// - transaction type in bits 31:28; value 8 means response with data
// - status in bits 27:24; zero means transaction done successfully
// - target transaction tag in 23:16, first payload byte pair in 15:0
// - later beats carry up to four byte pairs, earliest pair in bits 63:48
// - empty count gives the unused low bytes of the final beat
// - a 32-byte response carries all bytes in five beats with header
// - lanes without field or payload are don't care to receivers
`default_nettype none
package rrtxf_pkg;
  localparam int DATA_W = 64;
  localparam int PAIR_W = 16;
  localparam int EMPTY_W = 3;
  localparam int LEN_W = 9;
  localparam logic [3:0] FTYPE_RESPONSE = 4'hd;
  localparam logic [3:0] TTYPE_RESP_DATA = 4'h8;
  localparam logic [3:0] STATUS_DONE = 4'h0;
  localparam logic [1:0] RSVD_VALUE = 2'h0;
  localparam int ACK_HI = 63;
  localparam int ACK_LO = 59;
  localparam int RSVD_HI = 58;
  localparam int RSVD_LO = 57;
  localparam int CRF_BIT = 56;
  localparam int PRIO_HI = 55;
  localparam int PRIO_LO = 54;
  localparam int TT_HI = 53;
  localparam int TT_LO = 52;
  localparam int FTYPE_HI = 51;
  localparam int FTYPE_LO = 48;
  localparam int TTYPE_HI = 31;
  localparam int TTYPE_LO = 28;
  localparam int STAT_HI = 27;
  localparam int STAT_LO = 24;
  localparam int TAG_HI = 23;
  localparam int TAG_LO = 16;
  localparam int PAIR0_HI = 15;

  typedef struct packed {
    logic [4:0] ack_id;
    logic critical_request_flag;
    logic [1:0] prio;
    logic [1:0] tt;
    logic [3:0] status;
    logic [7:0] target_transaction_tag;
    logic [LEN_W-1:0] byte_len;
  } rrtxf_hdr_s;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [EMPTY_W-1:0] empty;
    logic [DATA_W-1:0] data;
  } rrtxf_beat_s;
endpackage
`default_nettype wire

// [rtl/rrtxf_pair_lane.sv]
// one 16-bit lane register of the outgoing beat
`default_nettype none
module rrtxf_pair_lane #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;
  always_comb
  begin
    q_d = load ? din : q_q;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q_q <= '0;
    else
      q_q <= q_d;
  end
  assign dout = q_q;
endmodule
`default_nettype wire

// [rtl/rrtxf_ctrl.sv]
// beat counter: turns a byte length into beat count and empty count
`default_nettype none
module rrtxf_ctrl (
  input wire logic [rrtxf_pkg::LEN_W-1:0] byte_len,
  output logic [rrtxf_pkg::LEN_W-1:0] beats,
  output logic [rrtxf_pkg::EMPTY_W-1:0] empty
);
  logic [rrtxf_pkg::LEN_W-1:0] total;
  always_comb
  begin
    // header takes 6 bytes of the first beat before payload
    total = byte_len + 9'h006;
    beats = (total + 9'h007) >> 3;
    empty = 3'(3'h0 - total[2:0]);
  end
endmodule
`default_nettype wire

// [rtl/rrtxf_top.sv]
// read response transmit framer top
`default_nettype none
module rrtxf_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REQ_VALID,
  input wire rrtxf_pkg::rrtxf_hdr_s REQ_HDR,
  output logic REQ_READY,
  input wire logic PAIR_VALID,
  input wire logic [rrtxf_pkg::PAIR_W-1:0] PAIR_DATA,
  output logic PAIR_READY,
  input wire logic TX_READY,
  output rrtxf_pkg::rrtxf_beat_s TX_BEAT
);
  typedef enum logic [2:0] {
    IDLE = 3'h1,
    FILL = 3'h2,
    SEND = 3'h4
  } rrtxf_state_e;

  rrtxf_state_e st_q, st_d;
  logic [1:0] slot_q, slot_d;
  logic [rrtxf_pkg::LEN_W-1:0] left_q, left_d;
  logic [rrtxf_pkg::LEN_W-1:0] nbeat_q, nbeat_d;
  logic [rrtxf_pkg::EMPTY_W-1:0] empty_q, empty_d;
  logic first_q, first_d;
  logic [rrtxf_pkg::EMPTY_W-1:0] tx_empty_q, tx_empty_d;
  logic req_rdy_q, req_rdy_d, pair_rdy_q, pair_rdy_d;
  logic [rrtxf_pkg::PAIR_W-1:0] lane_din [4];
  logic vld_q, vld_d, sop_q, sop_d, eop_q, eop_d;
  logic rdy_q, rdy_d;
  logic [3:0] load;
  logic [rrtxf_pkg::PAIR_W-1:0] lane_out [4];
  logic [rrtxf_pkg::LEN_W-1:0] beats;
  logic [rrtxf_pkg::EMPTY_W-1:0] empty;
  logic take, hdr_take;
  logic [47:0] hdr_word;

  rrtxf_ctrl u_ctrl (
    .byte_len(REQ_HDR.byte_len),
    .beats(beats),
    .empty(empty)
  );

  // lanes 0..2 hold the header high bits in the first beat, so every
  // output bit comes straight from a lane flop with no first-beat mux
  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_lane
    rrtxf_pair_lane #(.W(rrtxf_pkg::PAIR_W)) u_lane (
      .clk(CLK),
      .arst_n(ARST_N),
      .load(load[g]),
      .din(lane_din[g]),
      .dout(lane_out[g])
    );
  end

  always_comb
  begin
    // unused lanes left zero though receivers ignore them
    hdr_word = '0;
    hdr_word[rrtxf_pkg::ACK_HI-16:rrtxf_pkg::ACK_LO-16] =
      REQ_HDR.ack_id;
    hdr_word[rrtxf_pkg::RSVD_HI-16:rrtxf_pkg::RSVD_LO-16] =
      rrtxf_pkg::RSVD_VALUE;
    hdr_word[rrtxf_pkg::CRF_BIT-16] =
      REQ_HDR.critical_request_flag;
    hdr_word[rrtxf_pkg::PRIO_HI-16:rrtxf_pkg::PRIO_LO-16] =
      REQ_HDR.prio;
    hdr_word[rrtxf_pkg::TT_HI-16:rrtxf_pkg::TT_LO-16] =
      REQ_HDR.tt;
    hdr_word[rrtxf_pkg::FTYPE_HI-16:rrtxf_pkg::FTYPE_LO-16] =
      rrtxf_pkg::FTYPE_RESPONSE;
    hdr_word[rrtxf_pkg::TTYPE_HI-16:rrtxf_pkg::TTYPE_LO-16] =
      rrtxf_pkg::TTYPE_RESP_DATA;
    hdr_word[rrtxf_pkg::STAT_HI-16:rrtxf_pkg::STAT_LO-16] =
      REQ_HDR.status;
    hdr_word[rrtxf_pkg::TAG_HI-16:rrtxf_pkg::TAG_LO-16] =
      REQ_HDR.target_transaction_tag;
  end

  always_comb
  begin
    st_d = st_q;
    slot_d = slot_q;
    left_d = left_q;
    nbeat_d = nbeat_q;
    empty_d = empty_q;
    first_d = first_q;
    tx_empty_d = tx_empty_q;
    vld_d = vld_q;
    sop_d = sop_q;
    eop_d = eop_q;
    rdy_d = 1'b0;
    load = 4'h0;
    lane_din[0] = PAIR_DATA;
    lane_din[1] = PAIR_DATA;
    lane_din[2] = PAIR_DATA;
    lane_din[3] = PAIR_DATA;
    hdr_take = (st_q == IDLE) && REQ_VALID && rdy_q;
    take = (st_q == FILL) && PAIR_VALID && rdy_q;
    unique case (st_q)
      IDLE:
      begin
        rdy_d = 1'b1;
        if (hdr_take)
        begin
          load[2:0] = 3'h7;
          lane_din[0] = hdr_word[47:32];
          lane_din[1] = hdr_word[31:16];
          lane_din[2] = hdr_word[15:0];
          nbeat_d = beats;
          empty_d = empty;
          left_d = REQ_HDR.byte_len >> 1;
          first_d = 1'b1;
          slot_d = 2'h3; // first pair lands in bits 15:0
          st_d = FILL;
          rdy_d = 1'b0;
        end
      end
      FILL:
      begin
        rdy_d = 1'b1;
        if (take)
        begin
          load[slot_q] = 1'b1; // earliest pair in highest lane
          left_d = left_q - 9'h001;
          slot_d = slot_q + 2'h1;
        end
        // beat closes when lanes are full or bytes run out
        if (take && (slot_q == 2'h3 || left_q == 9'h001))
        begin
          st_d = SEND;
          rdy_d = 1'b0;
          vld_d = 1'b1;
          sop_d = first_q;
          eop_d = (nbeat_q == 9'h001);
          tx_empty_d = (nbeat_q == 9'h001) ? empty_q : 3'h0;
        end
      end
      SEND:
      begin
        if (TX_READY)
        begin
          vld_d = 1'b0;
          sop_d = 1'b0;
          eop_d = 1'b0;
          tx_empty_d = 3'h0;
          first_d = 1'b0;
          nbeat_d = nbeat_q - 9'h001;
          slot_d = 2'h0;
          st_d = eop_q ? IDLE : FILL;
          rdy_d = 1'b1;
        end
      end
      default:
      begin
        st_d = IDLE;
      end
    endcase
    // ready outputs registered so they come straight from flops
    req_rdy_d = rdy_d && (st_d == IDLE);
    pair_rdy_d = rdy_d && (st_d == FILL);
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_q <= IDLE;
      slot_q <= 2'h0;
      left_q <= '0;
      nbeat_q <= '0;
      empty_q <= '0;
      first_q <= 1'b0;
      tx_empty_q <= '0;
      req_rdy_q <= 1'b0;
      pair_rdy_q <= 1'b0;
      vld_q <= 1'b0;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      slot_q <= slot_d;
      left_q <= left_d;
      nbeat_q <= nbeat_d;
      empty_q <= empty_d;
      first_q <= first_d;
      tx_empty_q <= tx_empty_d;
      req_rdy_q <= req_rdy_d;
      pair_rdy_q <= pair_rdy_d;
      vld_q <= vld_d;
      sop_q <= sop_d;
      eop_q <= eop_d;
      rdy_q <= rdy_d;
    end
  end

  // stale lanes of a short last beat are don't care
  always_comb
  begin
    TX_BEAT.valid = vld_q;
    TX_BEAT.sop = sop_q;
    TX_BEAT.eop = eop_q;
    TX_BEAT.empty = tx_empty_q;
    TX_BEAT.data = {lane_out[0], lane_out[1], lane_out[2], lane_out[3]};
  end
  assign REQ_READY = req_rdy_q;
  assign PAIR_READY = pair_rdy_q;
endmodule
`default_nettype wire

// [verification/rrtxf_props.sv]
// port checker for the read response framer
`default_nettype none
module rrtxf_props (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic PAIR_READY,
  input wire logic TX_READY,
  input wire rrtxf_pkg::rrtxf_beat_s TX_BEAT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire v = TX_BEAT.valid;
  wire h = TX_BEAT.valid && TX_BEAT.sop;
  beat_hold_a: assert property (
    v && !TX_READY |=> $stable(TX_BEAT))
    else $error("beat moved while waiting");
  pair_block_a: assert property (v && !TX_READY |-> !PAIR_READY)
    else $error("pair ready while beat waits");
  hdr_once_a: assert property (
    REQ_VALID && REQ_READY |=> !REQ_READY [*2])
    else $error("header taken twice");
  hdr_rsvd_a: assert property (h |-> TX_BEAT.data[58:57] == 2'h0)
    else $error("reserved bits set");
  hdr_ftype_a: assert property (h |-> TX_BEAT.data[51:48] == 4'hd)
    else $error("bad format type");
  hdr_ttype_a: assert property (h |-> TX_BEAT.data[31:28] == 4'h8)
    else $error("bad transaction type");
  empty_mid_a: assert property (
    v && !TX_BEAT.eop |-> TX_BEAT.empty == 3'h0)
    else $error("empty count before end");
  eop_gap_a: assert property (
    v && TX_BEAT.eop && TX_READY |=> !v)
    else $error("beat right after end");
  cover property (v && !TX_READY);
  cover property (v && TX_BEAT.eop && TX_BEAT.empty == 3'h2);
  cover property (h && TX_BEAT.eop);
endmodule
bind rrtxf_top rrtxf_props i_rrtxf_props(.CLK(CLK), .ARST_N(ARST_N),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .PAIR_READY(PAIR_READY),
  .TX_READY(TX_READY), .TX_BEAT(TX_BEAT));
`default_nettype wire

// [verification/rrtxf_sink.sv]
// stalling sink model that takes the outgoing beats
`default_nettype none
module rrtxf_sink (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire rrtxf_pkg::rrtxf_beat_s beat,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  rrtxf_pkg::rrtxf_beat_s got[$];
  logic [1:0] cnt_q;
  // slow refuses three cycles of four so the source must hold its beat
  assign ready = !slow || cnt_q == 2'h3;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 2'h0;
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      if (beat.valid && ready)
        got.push_back(beat);
    end
  end
endmodule
`default_nettype wire

// [verification/rrtxf_top_tb.sv]
// testbench for the read response framer
`default_nettype none
module rrtxf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, ARST_N = 0, REQ_VALID = 0, PAIR_VALID = 0, slow = 0;
  rrtxf_pkg::rrtxf_hdr_s REQ_HDR = '0;
  logic [15:0] PAIR_DATA = '0;
  logic REQ_READY, PAIR_READY, TX_READY;
  rrtxf_pkg::rrtxf_beat_s TX_BEAT;
  int fails = 0, n_tests = 0;
  always #50 CLK = ~CLK;
  rrtxf_top i_rrtxf_top(.CLK(CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
    .REQ_HDR(REQ_HDR), .REQ_READY(REQ_READY), .PAIR_VALID(PAIR_VALID),
    .PAIR_DATA(PAIR_DATA), .PAIR_READY(PAIR_READY), .TX_READY(TX_READY),
    .TX_BEAT(TX_BEAT));
  rrtxf_sink i_rrtxf_sink(.clk(CLK), .arst_n(ARST_N), .slow(slow),
    .beat(TX_BEAT), .ready(TX_READY));
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hold(ref logic r);
    int k;
    for (k = 0; !r && k < 200; k++)
      @(negedge CLK);
    if (k == 200)
    begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic send(rrtxf_pkg::rrtxf_hdr_s h);
    int n, nb, b, p, i;
    logic [63:0] d, m;
    rrtxf_pkg::rrtxf_beat_s g;
    n = h.byte_len / 2;
    nb = 1 + (n + 2) / 4;
    i_rrtxf_sink.got.delete();
    REQ_HDR = h;
    REQ_VALID = 1;
    hold(REQ_READY);
    @(negedge CLK);
    REQ_VALID = 0;
    PAIR_VALID = 1;
    for (p = 0; p < n; p++)
    begin
      PAIR_DATA = {8'(2 * p + 1), 8'(2 * p + 2)};
      hold(PAIR_READY);
      @(negedge CLK);
    end
    PAIR_VALID = 0;
    for (b = 0; i_rrtxf_sink.got.size() < nb && b < 200; b++)
      @(negedge CLK);
    chk(64'(i_rrtxf_sink.got.size()), 64'(nb));
    if (b == 200)
      wrap_up();
    for (b = 0; b < nb; b++)
    begin
      g = i_rrtxf_sink.got[b];
      m = '1;
      d = {h.ack_id, 2'h0, h.critical_request_flag, h.prio, h.tt, 4'hd,
        16'h0, 4'h8, h.status, h.target_transaction_tag, 16'h0102};
      if (b == 0)
        m[47:32] = 16'h0;
      for (p = 0; p < 4 && b > 0; p++)
      begin
        i = 4 * b - 3 + p;
        d[63 - 16 * p -: 16] = {8'(2 * i + 1), 8'(2 * i + 2)};
        if (i >= n)
          m[63 - 16 * p -: 16] = 16'h0;
      end
      chk(g.data & m, d & m);
      chk({g.sop, g.eop}, {b == 0, b == nb - 1});
      if (b == nb - 1 && b > 0)
        chk(g.empty, 64'(8 - 2 * (n - 1 - 4 * (b - 1))));
    end
  endtask
  // 32-byte answer as seen on the wire, sink always ready
  task automatic t_nread;
    slow = 0;
    send('{5'h04, 1'b0, 2'h0, 2'h0, 4'h0, 8'h00, 9'h020});
  endtask
  // every header field away from zero, sink stalling, short last beat
  task automatic t_fields;
    slow = 1;
    send('{5'h1f, 1'b1, 2'h3, 2'h1, 4'h3, 8'ha5, 9'h00c});
  endtask
  // one pair only: header beat is both start and end
  task automatic t_single;
    slow = 1;
    send('{5'h0a, 1'b0, 2'h2, 2'h2, 4'h0, 8'h5a, 9'h002});
  endtask
  initial
  begin
    repeat (12) @(negedge CLK);
    ARST_N = 1;
    t_nread();
    t_fields();
    t_single();
    t_nread();
    wrap_up();
  end
endmodule
`default_nettype wire
